// [edge_sync.sv]
`timescale 1ns/1ps
// ****************************************
// Three-stage input synchroniser with edge
// ****************************************
module edge_sync
   import tmr_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic pin,
   output logic      rise
);
   logic s1;
   logic s2;
   logic s3;
   logic stable;

   // First stage feeds only the second; change counts when 2nd and 3rd agree
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s1     <= 1'b0;
         s2     <= 1'b0;
         s3     <= 1'b0;
         stable <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            stable <= s3;
         end
      end
   end

   assign rise = (s2 == s3) && s3 && !stable;
endmodule

// [pin_model.sv]
`timescale 1ns/1ps
// ****************************************
// Capture pin driver on the far side
// ****************************************
module pin_model (
   input  wire logic       mclk,
   input  wire logic [3:0] fire,
   output logic      [3:0] pins
);
   int hold [4] = '{0, 0, 0, 0};
   logic [3:0] fire_q = 4'h0;

   initial pins = 4'h0;

   // Request taken at the rising edge, clear of the bench's falling-edge writes
   always @(posedge mclk) fire_q <= fire;

   // Rising edge held 8 cycles so the synchroniser cannot miss it
   always @(negedge mclk) begin
      for (int i = 0; i < 4; i++) begin
         if (fire_q[i]) begin
            hold[i] = 8;
         end else if (hold[i] > 0) begin
            hold[i]--;
         end
         pins[i] = (hold[i] > 0);
      end
   end
endmodule

// [shadow_bank.sv]
`timescale 1ns/1ps
// ****************************************
// PWM shadow buffers, armed by channel 1 write
// ****************************************
module shadow_bank
   import tmr_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  rst_b,
   input  wire logic                  arm,
   input  wire logic                  load,
   input  wire logic                  transfer,
   input  wire logic [NCH*CNT_W-1:0]  regs,
   output logic      [NCH*CNT_W-1:0]  shadow
);
   logic armed;

   // Arm on channel 1 write, drop after the transfer
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         armed <= 1'b0;
      end else if (arm) begin
         armed <= 1'b1;
      end else if (transfer) begin
         armed <= 1'b0;
      end
   end

   // Load at start, or at counter clear if armed
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         shadow <= '0;
      end else if (load || (transfer && armed)) begin
         shadow <= regs;
      end
   end
endmodule

// [timer_pwm_freerun.sv]
`timescale 1ns/1ps
// Behaviour
// - One-shot rewrites act at once, may wrap
// - One-shot channel irq at equality cycle
// - Mode 100 with enable gives PWM
// - Channel 0 output toggles each PWM period
// - PWM enable moves counter FFFF to 0000
// - Period is value+1, width is value
// - Shadow loads at enable and at armed period clear
// - Only channel 1 write arms transfer
// - Period irq with counter clear
// - PWM channel irq at buffer match
// - Value zero gives constant inactive output
// - Value period+1 gives constant active output
// - Mode 101 free-run, capture select per channel
// - Free-run enable inverts compare-channel outputs, match inverts
// - Overflow after FFFF: irq, wrap, flag
// - Free-run compare writes act immediately
// - Capture edge latches count, raises irq
// - Free-run compare fires at value+1
// - Read buffer shows live counter
// - Option write with bit0 zero clears flag
module timer_pwm_freerun
   import tmr_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  rst_b,
   input  wire logic                  counter_enable_bit,
   input  wire logic [2:0]            timer_mode_field,
   input  wire logic [NCH-1:0]        chan_capture_select,
   input  wire reg_write_s            ccr_write,
   input  wire logic                  option_write,
   input  wire logic [7:0]            option_data,
   input  wire logic                  overflow_clear,
   input  wire logic [NCH-1:0]        capture_edge_in,
   output logic      [15:0]           counter_read_buffer,
   output logic      [NCH*CNT_W-1:0]  chan_capture_compare_reg,
   output logic                       overflow_flag,
   output tmr_events_s                events,
   output logic                       period_toggle_out,
   output logic      [NCH-1:1]        chan_pwm_out,
   output logic                       free_toggle_out0
);
   // ****************************************
   // Declarations
   // ****************************************
   logic [15:0]          cnt;
   logic                 en_d;
   logic                 started;
   logic [NCH-1:0]       cap_rise;
   logic [NCH*CNT_W-1:0] shadow;
   logic [NCH-1:0]       next_irq;
   logic [NCH-1:0]       free_out;
   logic [NCH-1:0]       free_flip;
   logic                 is_pwm;
   logic                 is_free;
   logic                 is_one;
   logic                 run;
   logic                 period_hit;
   logic [15:0]          next_cnt;

   assign is_pwm     = timer_mode_field == MODE_PWM;
   assign is_free    = timer_mode_field == MODE_FREE;
   assign is_one     = timer_mode_field == MODE_ONESHOT;
   assign run        = counter_enable_bit && started;
   assign period_hit = is_pwm && run && (cnt == shadow[CNT_W-1:0]);

   // ****************************************
   // Capture pin synchronisers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_sync
         edge_sync u_sync (
            .mclk  (mclk),
            .rst_b (rst_b),
            .pin   (capture_edge_in[g]),
            .rise  (cap_rise[g])
         );
      end
   endgenerate

   // ****************************************
   // Shadow buffers for PWM
   // ****************************************
   shadow_bank u_shadow (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .arm      (ccr_write.wr[1]),
      .load     (counter_enable_bit && !en_d),
      .transfer (period_hit),
      .regs     (chan_capture_compare_reg),
      .shadow   (shadow)
   );

   // Enable edge detect; counter sits at FFFF while idle
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         en_d    <= 1'b0;
         started <= 1'b0;
      end else begin
         en_d    <= counter_enable_bit;
         started <= counter_enable_bit;
      end
   end

   // Next count: PWM clears at period match, else plain wrap
   always_comb begin
      next_cnt = cnt + CNT_ONE;
      if (!counter_enable_bit) begin
         next_cnt = CNT_MAX;
      end else if (!started) begin
         next_cnt = CNT_ZERO;
      end else if (period_hit) begin
         next_cnt = CNT_ZERO;
      end
   end

   // ****************************************
   // Counter
   // ****************************************
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cnt <= CNT_MAX;
      end else begin
         cnt <= next_cnt;
      end
   end

   // Live counter copy for the read buffer
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         counter_read_buffer <= CNT_MAX;
      end else begin
         counter_read_buffer <= next_cnt;
      end
   end

   // ****************************************
   // Capture/compare registers
   // ****************************************
   generate
      for (g = 0; g < NCH; g++) begin : g_ccr
         // Capture wins over a software write in the same cycle
         always_ff @(posedge mclk) begin
            if (!rst_b) begin
               chan_capture_compare_reg[g*CNT_W +: CNT_W] <= CNT_ZERO;
            end else if (is_free && run && chan_capture_select[g] && cap_rise[g]) begin
               chan_capture_compare_reg[g*CNT_W +: CNT_W] <= cnt;
            end else if (ccr_write.wr[g]) begin
               chan_capture_compare_reg[g*CNT_W +: CNT_W] <= ccr_write.data;
            end
         end

         // Interrupt timing per mode
         always_comb begin
            next_irq[g] = 1'b0;
            if (run && is_free) begin
               if (chan_capture_select[g]) begin
                  next_irq[g] = cap_rise[g];
               end else begin
                  // Live value, fires one count after equality
                  next_irq[g] = cnt == chan_capture_compare_reg[g*CNT_W +: CNT_W];
               end
            end else if (run && is_pwm) begin
               if (g == 0) begin
                  next_irq[g] = period_hit;
               end else begin
                  next_irq[g] = next_cnt == shadow[g*CNT_W +: CNT_W];
               end
            end else if (run && is_one && g != 0) begin
               next_irq[g] = next_cnt == chan_capture_compare_reg[g*CNT_W +: CNT_W];
            end
         end

         // Free-run toggle: invert on enable and on each match
         assign free_flip[g] = is_free && !chan_capture_select[g]
                               && ((counter_enable_bit && !en_d) || next_irq[g]);
         always_ff @(posedge mclk) begin
            if (!rst_b) begin
               free_out[g] <= 1'b0;
            end else begin
               free_out[g] <= free_out[g] ^ free_flip[g];
            end
         end
      end
   endgenerate

   // ****************************************
   // Interrupt pulses
   // ****************************************
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         events <= '0;
      end else begin
         events.chan_irq     <= next_irq;
         events.overflow_irq <= is_free && run && cnt == CNT_MAX;
      end
   end

   // Sticky overflow flag; a new overflow beats any clear
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         overflow_flag <= 1'b0;
      end else if (is_free && run && cnt == CNT_MAX) begin
         overflow_flag <= 1'b1;
      end else if (overflow_clear || (option_write && !option_data[OPT_OVF_BIT])) begin
         overflow_flag <= 1'b0;
      end
   end

   // ****************************************
   // Pin outputs
   // ****************************************
   // Channel 0: PWM toggles per period, free-run from compare
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         period_toggle_out <= 1'b0;
      end else if (!counter_enable_bit) begin
         period_toggle_out <= 1'b0;
      end else if (is_pwm && period_hit) begin
         period_toggle_out <= !period_toggle_out;
      end
   end

   // Free-run channel 0 pin; takes the flip itself so it lands with the irq
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         free_toggle_out0 <= 1'b0;
      end else begin
         free_toggle_out0 <= free_out[0] ^ free_flip[0];
      end
   end

   // Channels 1-3: active while count below width, so 0 and period+1 work
   generate
      for (g = 1; g < NCH; g++) begin : g_out
         always_ff @(posedge mclk) begin
            if (!rst_b) begin
               chan_pwm_out[g] <= 1'b0;
            end else if (is_pwm) begin
               chan_pwm_out[g] <= counter_enable_bit
                  && ({1'b0, next_cnt} < {1'b0, shadow[g*CNT_W +: CNT_W]});
            end else if (is_free) begin
               chan_pwm_out[g] <= free_out[g] ^ free_flip[g];
            end else begin
               chan_pwm_out[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ****************************************
   // Checks
   // ****************************************
   property p_ovf_set;
      @(posedge mclk) disable iff (!rst_b)
      (is_free && run && cnt == CNT_MAX) |=> overflow_flag && events.overflow_irq;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

   property p_ovf_sticky;
      @(posedge mclk) disable iff (!rst_b)
      (overflow_flag && !overflow_clear && !option_write) |=> overflow_flag;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("flag dropped");

   property p_opt_clear;
      @(posedge mclk) disable iff (!rst_b)
      (option_write && !option_data[OPT_OVF_BIT] && !(is_free && run && cnt == CNT_MAX))
         |=> !overflow_flag;
   endproperty
   a_opt_clear: assert property (p_opt_clear) else $error("flag not cleared");

   property p_pwm_clear;
      @(posedge mclk) disable iff (!rst_b)
      period_hit && counter_enable_bit |=> cnt == CNT_ZERO && events.chan_irq[0];
   endproperty
   a_pwm_clear: assert property (p_pwm_clear) else $error("period clear missed");

   property p_start;
      @(posedge mclk) disable iff (!rst_b)
      (counter_enable_bit && !started) ##1 counter_enable_bit |-> cnt == CNT_ZERO;
   endproperty
   a_start: assert property (p_start) else $error("start not from zero");

   property p_toggle;
      @(posedge mclk) disable iff (!rst_b)
      (period_hit && counter_enable_bit) |=> period_toggle_out != $past(period_toggle_out);
   endproperty
   a_toggle: assert property (p_toggle) else $error("channel 0 no toggle");

   property p_capture;
      @(posedge mclk) disable iff (!rst_b)
      (is_free && run && chan_capture_select[3] && cap_rise[3])
         |=> chan_capture_compare_reg[4*CNT_W-1:3*CNT_W] == $past(cnt) && events.chan_irq[3];
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed");

   property p_zero_duty;
      @(posedge mclk) disable iff (!rst_b)
      (is_pwm && shadow[3*CNT_W-1:2*CNT_W] == CNT_ZERO) [*2] |-> !chan_pwm_out[2];
   endproperty
   a_zero_duty: assert property (p_zero_duty) else $error("zero duty active");

   property p_free_cmp;
      @(posedge mclk) disable iff (!rst_b)
      (is_free && run && !chan_capture_select[2]
       && cnt == chan_capture_compare_reg[3*CNT_W-1:2*CNT_W]) |=> events.chan_irq[2];
   endproperty
   a_free_cmp: assert property (p_free_cmp) else $error("compare irq missed");
endmodule

// [timer_pwm_freerun_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
   $display("BAD %0t got %h want %h", $time, a, b); end end
module timer_pwm_freerun_tb;
   import tmr_pkg::*;
   logic                 mclk = 1'b0;
   logic                 rst_b = 1'b0;
   logic                 en = 1'b0;
   logic [2:0]           mode = 3'h0;
   logic [NCH-1:0]       capsel = 4'h0;
   reg_write_s           ccr_write = '0;
   logic                 option_write = 1'b0;
   logic [7:0]           option_data = 8'h00;
   logic                 overflow_clear = 1'b0;
   logic [3:0]           fire = 4'h0;
   logic [NCH-1:0]       pins;
   logic [15:0]          cnt;
   logic [NCH*CNT_W-1:0] ccr;
   logic                 flag;
   tmr_events_s          events;
   logic                 tog0;
   logic [NCH-1:1]       pwm;
   logic                 ftog0;
   logic                 t;
   logic [15:0]          c;
   int                   fails = 0;
   int                   num_checks = 0;
   int                   cyc = 0;
   int                   wt = 0;
   int                   hi [4];

   always #4 mclk = ~mclk;

   pin_model pm (.mclk(mclk), .fire(fire), .pins(pins));

   timer_pwm_freerun dut (.mclk(mclk), .rst_b(rst_b), .counter_enable_bit(en),
      .timer_mode_field(mode), .chan_capture_select(capsel), .ccr_write(ccr_write),
      .option_write(option_write), .option_data(option_data),
      .overflow_clear(overflow_clear), .capture_edge_in(pins),
      .counter_read_buffer(cnt), .chan_capture_compare_reg(ccr),
      .overflow_flag(flag), .events(events), .period_toggle_out(tog0),
      .chan_pwm_out(pwm), .free_toggle_out0(ftog0));

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic give_verdict;
      if (fails == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One-cycle compare register write
   task automatic wr(input int ch, input logic [15:0] v);
      @(negedge mclk);
      ccr_write.wr = 4'h1 << ch;
      ccr_write.data = v;
      @(negedge mclk);
      ccr_write.wr = 4'h0;
   endtask

   // Bounded wait on one event bit: 0 overflow, 1+ch channel
   task automatic wait_ev(input int idx, input int lim);
      int n;
      n = 0;
      @(negedge mclk);
      while (events[idx] !== 1'b1 && n < lim) begin
         @(negedge mclk);
         n++;
      end
      `CHK(events[idx], 1'b1);
   endtask

   // One full period of 10 counts after a period irq
   task automatic period_check(input int e1, input int e2, input int e3);
      hi = '{0, 0, 0, 0};
      t = tog0;
      for (int j = 0; j < 10; j++) begin
         @(negedge mclk);
         for (int k = 1; k < 4; k++) hi[k] += int'(pwm[k] === 1'b1);
         if (events.chan_irq[1] === 1'b1) `CHK(cnt, 16'h0003);
      end
      `CHK(events.chan_irq[0], 1'b1);
      `CHK(cnt, 16'h0000);
      `CHK(tog0, ~t);
      `CHK(hi[1], e1);
      `CHK(hi[2], e2);
      `CHK(hi[3], e3);
   endtask

   // Hang guard well above one full overflow pass
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 90000) begin
         fails++;
         give_verdict();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(negedge mclk);
      rst_b = 1'b1;
      @(negedge mclk);
      `CHK(cnt, 16'hFFFF);
      `CHK(flag, 1'b0);
      // One-shot: channel 2 irq lands in the equality cycle
      mode = MODE_ONESHOT;
      wr(2, 16'h0004);
      @(negedge mclk);
      en = 1'b1;
      wait_ev(3, 20);
      `CHK(cnt, 16'h0004);
      en = 1'b0;
      // PWM: period 9, widths 3, 0 and 10; channel 1 written last
      mode = MODE_PWM;
      wr(0, 16'h0009);
      wr(2, 16'h0000);
      wr(3, 16'h000A);
      wr(1, 16'h0003);
      @(negedge mclk);
      en = 1'b1;
      wait_ev(1, 40);
      period_check(3, 0, 10);
      // Channel 2 write alone stays out of the buffers
      wr(2, 16'h0005);
      wait_ev(1, 40);
      period_check(3, 0, 10);
      wr(1, 16'h0003);
      wait_ev(1, 40);
      period_check(3, 5, 10);
      // Free-run: channel 3 captures, others compare
      @(negedge mclk);
      en = 1'b0;
      mode = MODE_FREE;
      capsel = 4'b1000;
      wr(0, 16'h0014);
      @(negedge mclk);
      en = 1'b1;
      repeat (2) @(negedge mclk);
      t = ftog0;
      `CHK(pwm, 3'b011);
      wait_ev(1, 100);
      `CHK(cnt, 16'h0015);
      `CHK(ftog0, ~t);
      `CHK(pwm, 3'b000);
      c = cnt;
      wr(1, c + 16'h0028);
      wait_ev(2, 100);
      `CHK(cnt, c + 16'h0029);
      fire = 4'b1000;
      @(negedge mclk);
      fire = 4'h0;
      wait_ev(4, 20);
      `CHK(ccr[63:48], cnt - 16'h0001);
      // Clear raised in the overflow cycle itself: the set must win
      while (cnt !== CNT_MAX && wt < 70000) begin
         @(negedge mclk);
         wt++;
      end
      overflow_clear = 1'b1;
      wait_ev(0, 4);
      overflow_clear = 1'b0;
      `CHK(cnt, 16'h0000);
      @(negedge mclk);
      `CHK(flag, 1'b1);
      option_write = 1'b1;
      option_data = 8'h01;
      @(negedge mclk);
      option_write = 1'b0;
      repeat (3) @(negedge mclk);
      `CHK(flag, 1'b1);
      overflow_clear = 1'b1;
      @(negedge mclk);
      overflow_clear = 1'b0;
      @(negedge mclk);
      `CHK(flag, 1'b0);
      give_verdict();
   end
endmodule

// [tmr_pkg.sv]
package tmr_pkg;

   // ****************************************
   // Widths and counter values
   // ****************************************
   localparam int          CNT_W     = 16;
   localparam int          NCH       = 4;
   localparam logic [15:0] CNT_MAX   = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO  = 16'h0000;
   localparam logic [15:0] CNT_ONE   = 16'h0001;

   // ****************************************
   // Mode field encodings
   // ****************************************
   localparam logic [2:0]  MODE_ONESHOT = 3'h3;
   localparam logic [2:0]  MODE_PWM     = 3'h4;
   localparam logic [2:0]  MODE_FREE    = 3'h5;

   // Option register: overflow flag sits in bit 0
   localparam int          OPT_OVF_BIT  = 0;

   // Software write strobe with data
   typedef struct packed {
      logic [NCH-1:0]   wr;
      logic [15:0]      data;
   } reg_write_s;

   // Per-cycle event pulses
   typedef struct packed {
      logic [NCH-1:0]   chan_irq;
      logic             overflow_irq;
   } tmr_events_s;

endpackage
